// ### design/refclk_pkg.sv
// Operation
// - Run-in-sleep bit set keeps output toggling in Sleep; clear stops it.
// - Source select 1 picks crystal, 0 picks system clock as base.
// - Divider code in bits 11..8 divides base clock by two to the power of (code plus one).
// - Bit 14 and bits 7..0 ignore writes and read as zero.
package refclk_pkg;
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int WORD_LSB = 2;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h004;

	// Control register layout
	localparam int CTRL_W = 16;
	localparam int ENABLE_BIT = 15;
	localparam int SLEEP_RUN_BIT = 13;
	localparam int SOURCE_BIT = 12;
	localparam int DIV_LSB = 8;
	localparam int DIV_W = 4;
	localparam int CTRL_LANE = 1;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_WRITE_MASK = 16'hbf00;

	// Status register layout
	localparam int STAT_PIN_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int STAT_SLEEP_BIT = 2;

	// Source select encoding
	localparam logic SOURCE_SYSTEM = 1'b0;
	localparam logic SOURCE_CRYSTAL = 1'b1;

	// Divider counter width covers the largest division
	localparam int COUNT_W = 15;

	// Response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;
endpackage : refclk_pkg

// ### design/refclk_divider.sv
module refclk_divider
	import refclk_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tick,
	input wire logic run,
	input wire logic restart,
	input wire logic [DIV_W-1:0] code,
	output logic toggle
);
	logic [COUNT_W-1:0] count_r;
	logic [COUNT_W-1:0] count_nxt;
	logic [COUNT_W-1:0] limit;
	logic [COUNT_W:0] full_span;

	// Ticks per output half period minus one
	always_comb begin
		full_span = (COUNT_W+1)'(1) << code;
		limit = COUNT_W'(full_span - (COUNT_W+1)'(1));
	end

	// Count base ticks, request a toggle on reaching the limit
	always_comb begin
		count_nxt = count_r;
		toggle = 1'b0;
		if (restart) begin
			count_nxt = '0;
		end else if (run && tick) begin
			if (count_r >= limit) begin
				count_nxt = '0;
				toggle = 1'b1;
			end else begin
				count_nxt = count_r + COUNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule : refclk_divider

// ### design/reference_clock_output.sv
module reference_clock_output
	import refclk_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [STRB_W-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic xtal_edge,
	input wire logic sleep_mode,
	output logic refclk_output_pin
);
	// Write channel state
	wr_state_t wr_state_r;
	wr_state_t wr_state_nxt;
	logic awready_r;
	logic awready_nxt;
	logic wready_r;
	logic wready_nxt;
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic aw_held_r;
	logic aw_held_nxt;
	logic w_held_r;
	logic w_held_nxt;
	logic [ADDR_W-1:0] waddr_r;
	logic [ADDR_W-1:0] waddr_nxt;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] wdata_nxt;
	logic [STRB_W-1:0] wstrb_r;
	logic [STRB_W-1:0] wstrb_nxt;

	// Read channel state
	rd_state_t rd_state_r;
	rd_state_t rd_state_nxt;
	logic arready_r;
	logic arready_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	// Control and output state
	logic [CTRL_W-1:0] ctrl_r;
	logic [CTRL_W-1:0] ctrl_nxt;
	logic pin_r;
	logic pin_nxt;
	logic sleep_r;
	logic sleep_nxt;

	// Write decode helpers
	logic aw_take;
	logic w_take;
	logic aw_have;
	logic w_have;
	logic wr_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [STRB_W-1:0] wr_strb;
	logic [ADDR_W-1:0] wr_word;
	logic [ADDR_W-1:0] rd_word;

	// Field views of the control register
	logic out_enable;
	logic run_in_sleep;
	logic source_select;
	logic [DIV_W-1:0] divider_code;
	logic running;
	logic base_tick;
	logic restart;
	logic toggle;

	assign out_enable = ctrl_r[ENABLE_BIT];
	assign run_in_sleep = ctrl_r[SLEEP_RUN_BIT];
	assign source_select = ctrl_r[SOURCE_BIT];
	assign divider_code = ctrl_r[DIV_LSB +: DIV_W];

	// Word-aligned addresses, byte offset bits ignored
	assign wr_word = {wr_addr[ADDR_W-1:WORD_LSB], WORD_LSB'(0)};
	assign rd_word = {araddr[ADDR_W-1:WORD_LSB], WORD_LSB'(0)};

	// Write channel: address and data taken in either order
	always_comb begin
		aw_take = awvalid && awready_r;
		w_take = wvalid && wready_r;
		aw_have = aw_held_r || aw_take;
		w_have = w_held_r || w_take;
		wr_addr = aw_held_r ? waddr_r : awaddr;
		wr_data = w_held_r ? wdata_r : wdata;
		wr_strb = w_held_r ? wstrb_r : wstrb;
		wr_fire = 1'b0;
		wr_state_nxt = wr_state_r;
		awready_nxt = awready_r;
		wready_nxt = wready_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		waddr_nxt = aw_take ? awaddr : waddr_r;
		wdata_nxt = w_take ? wdata : wdata_r;
		wstrb_nxt = w_take ? wstrb : wstrb_r;
		unique case (wr_state_r)
			WR_IDLE: begin
				if (aw_have && w_have) begin
					wr_fire = 1'b1;
					wr_state_nxt = WR_RESP;
					bvalid_nxt = 1'b1;
					awready_nxt = 1'b0;
					wready_nxt = 1'b0;
					aw_held_nxt = 1'b0;
					w_held_nxt = 1'b0;
					if (wr_word == CTRL_OFFSET || wr_word == STAT_OFFSET) begin
						bresp_nxt = RESP_OKAY;
					end else begin
						bresp_nxt = RESP_SLVERR;
					end
				end else begin
					aw_held_nxt = aw_have;
					w_held_nxt = w_have;
					awready_nxt = !aw_have;
					wready_nxt = !w_have;
				end
			end
			WR_RESP: begin
				if (bready) begin
					wr_state_nxt = WR_IDLE;
					bvalid_nxt = 1'b0;
					awready_nxt = 1'b1;
					wready_nxt = 1'b1;
				end
			end
			default: begin
				wr_state_nxt = WR_IDLE;
				bvalid_nxt = 1'b0;
				awready_nxt = 1'b1;
				wready_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_state_r <= WR_IDLE;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= DATA_ZERO;
			wstrb_r <= '0;
		end else begin
			wr_state_r <= wr_state_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
		end
	end

	// Read channel: one read at a time, data captured at address handshake
	always_comb begin
		rd_state_nxt = rd_state_r;
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		unique case (rd_state_r)
			RD_IDLE: begin
				if (arvalid && arready_r) begin
					rd_state_nxt = RD_RESP;
					arready_nxt = 1'b0;
					rvalid_nxt = 1'b1;
					rresp_nxt = RESP_OKAY;
					rdata_nxt = DATA_ZERO;
					if (rd_word == CTRL_OFFSET) begin
						rdata_nxt[CTRL_W-1:0] = ctrl_r & CTRL_WRITE_MASK;
					end else if (rd_word == STAT_OFFSET) begin
						rdata_nxt[STAT_PIN_BIT] = pin_r;
						rdata_nxt[STAT_RUN_BIT] = running;
						rdata_nxt[STAT_SLEEP_BIT] = sleep_r;
					end else begin
						rresp_nxt = RESP_SLVERR;
					end
				end
			end
			RD_RESP: begin
				if (rready) begin
					rd_state_nxt = RD_IDLE;
					arready_nxt = 1'b1;
					rvalid_nxt = 1'b0;
				end
			end
			default: begin
				rd_state_nxt = RD_IDLE;
				arready_nxt = 1'b1;
				rvalid_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_state_r <= RD_IDLE;
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= DATA_ZERO;
		end else begin
			rd_state_r <= rd_state_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Control register update through the upper control byte lane
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_fire && wr_word == CTRL_OFFSET && wr_strb[CTRL_LANE]) begin
			ctrl_nxt = wr_data[CTRL_W-1:0] & CTRL_WRITE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Base clock choice and run gating
	always_comb begin
		if (source_select == SOURCE_CRYSTAL) begin
			base_tick = xtal_edge;
		end else begin
			base_tick = 1'b1;
		end
		running = out_enable && !(sleep_mode && !run_in_sleep);
		// Divider restarts when disabled or its code changes; software should
		// disable first, a change while enabled only restarts the count
		restart = !out_enable || (ctrl_nxt[DIV_LSB +: DIV_W] != divider_code);
	end

	refclk_divider divider_u (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(base_tick),
		.run(running),
		.restart(restart),
		.code(divider_code),
		.toggle(toggle)
	);

	// Output pin: low when disabled, held in Sleep unless allowed to run
	always_comb begin
		sleep_nxt = sleep_mode;
		pin_nxt = pin_r;
		if (!out_enable) begin
			pin_nxt = 1'b0;
		end else if (running && toggle) begin
			pin_nxt = !pin_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_r <= 1'b0;
			sleep_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	// Port drive straight from flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
	assign refclk_output_pin = pin_r;
endmodule : reference_clock_output

// ### test/refclk_chk.sv
module refclk_chk
	import refclk_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [STRB_W-1:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rvalid,
	input wire logic xtal_edge,
	input wire logic sleep_mode,
	input wire logic refclk_output_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] age_r, age_nxt;
	logic wr_c;
	// Shadow of control high byte and cycles since its last write
	always_comb begin
		wr_c = awvalid && awready && wvalid && wready && awaddr == CTRL_OFFSET && wstrb[CTRL_LANE];
		sh_nxt = wr_c ? wdata[15:8] : sh_r;
		age_nxt = wr_c ? 3'h0 : (age_r == 3'h7 ? age_r : age_r + 3'h1);
	end
	always_ff @(posedge clk) begin
		sh_r <= sys_rst ? 8'h00 : sh_nxt;
		age_r <= sys_rst ? 3'h0 : age_nxt;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_off;
		!sh_r[7] |=> !refclk_output_pin;
	endproperty
	property p_frz;
		sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2) && !sh_r[5] && age_r > 3'h3
			|-> $stable(refclk_output_pin);
	endproperty
	property p_sys;
		sh_r[7] && !sh_r[4] && sh_r[3:0] == 4'h0 && age_r > 3'h3 && !sleep_mode && !$past(sleep_mode)
			&& !$past(sleep_mode, 2) |-> refclk_output_pin != $past(refclk_output_pin);
	endproperty
	property p_crys;
		sh_r[7] && sh_r[4] && age_r > 3'h3 && !$past(xtal_edge) && !$past(xtal_edge, 2)
			|-> $stable(refclk_output_pin);
	endproperty
	property p_zero;
		rvalid |-> rdata[31:16] == 16'h0000 && !rdata[14] && rdata[7:3] == 5'h00;
	endproperty
	a_off: assert property (p_off) else $error("pin active while disabled");
	a_frz: assert property (p_frz) else $error("pin moved in sleep");
	a_sys: assert property (p_sys) else $error("system clock code 0 not toggling");
	a_crys: assert property (p_crys) else $error("pin moved without crystal tick");
	a_zero: assert property (p_zero) else $error("unused read bits not zero");
	c_sleep: cover property (sleep_mode && sh_r[7] && sh_r[5]);
	c_crys: cover property (sh_r[7] && sh_r[4] && refclk_output_pin);
	c_read: cover property (rvalid);
endmodule : refclk_chk

bind reference_clock_output refclk_chk u_chk(.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
	.wvalid, .wready, .rdata, .rvalid, .xtal_edge, .sleep_mode, .refclk_output_pin);

// ### test/refclk_sink.sv
module refclk_sink (
	input wire logic clk,
	input wire logic refclk_output_pin,
	input wire logic xtal_edge,
	output int toggles,
	output int half_clk,
	output int half_xtl
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_r = 1'b0;
	int cc;
	int xc;
	// Spacing of pin changes in clocks and crystal ticks
	always @(posedge clk) begin
		if (refclk_output_pin !== last_r) begin
			toggles <= toggles + 1;
			half_clk <= cc;
			half_xtl <= xc;
			cc <= 1;
			xc <= int'(xtal_edge);
		end else begin
			cc <= cc + 1;
			xc <= xc + int'(xtal_edge);
		end
		last_r <= refclk_output_pin;
	end
endmodule : refclk_sink

// ### test/tb_top.sv
module tb_top
	import refclk_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, sleep_mode;
	logic xtal_edge = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pin;
	logic [1:0] bresp, rresp;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [2:0] awprot = 3'h0;
	logic [2:0] arprot = 3'h0;
	logic [7:0] lf = 8'h5f;
	int toggles, half_clk, half_xtl, n_fail, tests_run, ctrl_m;
	reference_clock_output uut(.clk, .sys_rst, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .xtal_edge, .sleep_mode, .refclk_output_pin(pin));
	refclk_sink sink(.clk, .refclk_output_pin(pin), .xtal_edge, .toggles, .half_clk, .half_xtl);
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nx
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic stop_test();
		$display("fails=%0d checks=%0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	// Write cycle, valids dropped as each is taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd
	// Control write with model update and read-back
	task automatic wc(input logic [31:0] v, input logic [3:0] s);
		logic [31:0] d;
		logic [1:0] r;
		wr(CTRL_OFFSET, v, s, r);
		chk(32'(r), 32'(RESP_OKAY));
		if (s[1]) ctrl_m = int'(v) & 32'h0000_bf00;
		rd(CTRL_OFFSET, d, r);
		chk(d, 32'(ctrl_m));
	endtask : wc
	task automatic wt(input int n);
		int t0;
		t0 = toggles;
		while (toggles < t0 + n) @(posedge clk);
	endtask : wt
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Random crystal ticks and protection bits
	always @(posedge clk) begin
		lf <= nx(lf);
		xtal_edge <= lf[0];
		awprot <= lf[3:1];
		arprot <= lf[6:4];
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		stop_test();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int t0;
		int cs[8];
		cs = '{0, 1, 2, 3, 4, 5, 6, 15};
		sys_rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, sleep_mode} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(CTRL_OFFSET, d, r);
		chk(d, 32'h0000_0000);
		wc(32'hffff_7fff, 4'hf);
		wc(32'h0000_9f00, 4'hd);
		wr(12'h100, 32'hffff_ffff, 4'hf, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(12'h100, d, r);
		chk({d[29:0], r}, 32'(RESP_SLVERR));
		foreach (cs[i]) begin
			wc(32'(cs[i]) << 8, 4'hf);
			wc(32'h8000 | (32'(cs[i]) << 8), 4'hf);
			wt(2);
			chk(32'(half_clk), 32'(1) << cs[i]);
			wc(32'(cs[i]) << 8, 4'hf);
		end
		wc(32'h0000_1200, 4'hf);
		wc(32'h0000_9200, 4'hf);
		wt(2);
		chk(32'(half_xtl), 32'h4);
		for (int k = 0; k < 2; k++) begin
			wc(k ? 32'h0000_0000 : 32'h0000_1200, 4'hf);
			wc(k ? 32'h0000_a000 : 32'h0000_8000, 4'hf);
			sleep_mode <= 1'b1;
			repeat (3) @(posedge clk);
			t0 = toggles;
			repeat (20) @(posedge clk);
			chk(32'(toggles - t0), k ? 32'd20 : 32'd0);
			rd(STAT_OFFSET, d, r);
			chk(32'(d[2:1]), k ? 32'h3 : 32'h2);
			sleep_mode <= 1'b0;
		end
		wc(32'h0000_0000, 4'hf);
		wr(STAT_OFFSET, 32'hffff_ffff, 4'hf, r);
		chk(32'(r), 32'(RESP_OKAY));
		rd(STAT_OFFSET, d, r);
		chk(d, 32'h0);
		stop_test();
	end
endmodule : tb_top
